//--- tec_pkg.sv
// Package for the timer event and flag control block.
// Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
package tec_pkg;

   // Printed register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_BV_CLEAR = 8'h06;
   localparam logic [7:0] IDX_BV_SET = 8'h07;
   localparam logic [7:0] IDX_EV_CTRL = 8'h09;
   localparam logic [7:0] IDX_INT_EN = 8'h0A;
   localparam logic [7:0] IDX_INT_FLAGS = 8'h0B;
   localparam logic [7:0] IDX_DEBUG = 8'h0E;
   localparam logic [7:0] IDX_COUNT = 8'h20;
   localparam logic [7:0] IDX_PERIOD_BUF = 8'h36;
   localparam logic [7:0] IDX_CMP0_BUF = 8'h38;

   // Field positions.
   localparam int BV_PER = 0;
   localparam int BV_CMP0 = 1;
   localparam int EV_A_EN = 0;
   localparam int EV_A_ACT_LO = 1;
   localparam int EV_B_EN = 4;
   localparam int EV_B_ACT_LO = 5;
   localparam int INT_WRAP = 0;
   localparam int INT_CMP0 = 4;
   localparam int DBG_RUN = 0;

   // Reset values.
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_PERIOD = 16'hFFFF;
   localparam logic [15:0] RST_CMP = 16'h0000;

   // Input A actions.
   localparam logic [2:0] A_COUNT_RISING = 3'h0;
   localparam logic [2:0] A_COUNT_EITHER_EDGE = 3'h1;
   localparam logic [2:0] A_COUNT_WHILE_HIGH = 3'h2;
   localparam logic [2:0] A_DIRECTION_BY_EVENT = 3'h3;
   // Input B actions.
   localparam logic [2:0] B_NONE = 3'h0;
   localparam logic [2:0] B_DIRECTION_BY_EVENT = 3'h3;
   localparam logic [2:0] B_RESTART_RISING = 3'h4;
   localparam logic [2:0] B_RESTART_EITHER_EDGE = 3'h5;
   localparam logic [2:0] B_RESTART_WHILE_HIGH = 3'h6;

   // Bus phase state, Gray coded.
   typedef enum logic [1:0] {
      TEC_IDLE = 2'b00,
      TEC_WRITE = 2'b01,
      TEC_READ = 2'b11
   } tec_phase_type;

   // Event sample pair.
   typedef struct packed {
      logic a;
      logic b;
   } tec_events_type;

   // Counter core hooks.
   typedef struct packed {
      logic count_step;
      logic count_down;
      logic restart;
   } tec_core_cmd_type;

endpackage : tec_pkg

//--- tec_timer_ctrl.sv
// Control and status logic of a 16-bit timer in normal mode.
// Assumes a 20 MHz system clock, an AHB-Lite master and a counter core outside.
`timescale 1ns/1ps
module tec_timer_ctrl
   import tec_pkg::*;
#(
   parameter int CHANNELS = 3
) (
   // Clock and reset.
   input wire logic CLK_SYS_I,
   input wire logic RESETN_I,
   // AHB-Lite slave.
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   // Event inputs and debug state.
   input wire logic EVENT_A_I,
   input wire logic EVENT_B_I,
   input wire logic DEBUG_BREAK_I,
   // Counter core hooks.
   input wire logic PRESCALED_TICK_I,
   input wire logic UPDATE_I,
   input wire logic AT_TOP_I,
   input wire logic AT_BOTTOM_I,
   input wire logic [2:0] WAVEFORM_MODE_I,
   input wire logic [15:0] COUNT_VALUE_I,
   output logic COUNT_STEP_O,
   output logic COUNT_DOWN_O,
   output logic RESTART_O,
   output logic TIMER_RUN_O,
   output logic [16*CHANNELS-1:0] COMPARE_REGISTER_O,
   output logic [15:0] PERIOD_BUFFER_O,
   // Interrupt requests.
   output logic WRAP_IRQ_O,
   output logic [CHANNELS-1:0] COMPARE_IRQ_O
);

   // The field layout holds exactly three compare channels.
   if (CHANNELS != 3) begin : g_bad_channels
      $error("CHANNELS must be 3");
   end

   tec_phase_type phase_q;
   logic [7:0] idx_q;
   logic [7:0] bv_q;
   logic [7:0] ev_ctrl_q;
   logic [7:0] int_en_q;
   logic [7:0] flags_q;
   logic [7:0] bv_d;
   logic [7:0] flags_d;
   logic [7:0] debug_q;
   logic [15:0] period_buf_q;
   logic [15:0] cmp_buf_q [CHANNELS];
   logic [15:0] cmp_q [CHANNELS];
   tec_events_type ev_q;
   logic dir_q;
   logic [31:0] rdata_d;
   logic wr_en;
   logic run;
   logic a_on;
   logic b_on;
   logic a_rise;
   logic a_any;
   logic b_rise;
   logic b_any;
   logic step;
   logic [2:0] act_a;
   logic [2:0] act_b;
   logic [CHANNELS-1:0] cmp_hit;
   logic wrap_hit;
   tec_core_cmd_type cmd;

   // Address phase capture; every transfer completes with no wait state.
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         phase_q <= TEC_IDLE;
         idx_q <= RST_BYTE;
      end else if (HREADY_I) begin
         if (HSEL_I && HTRANS_I[1]) begin
            phase_q <= HWRITE_I ? TEC_WRITE : TEC_READ;
            idx_q <= HADDR_I[9:2];
         end else begin
            phase_q <= TEC_IDLE;
         end
      end
   end

   assign wr_en = (phase_q == TEC_WRITE);
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O = 1'b0;

   // Read mux; unmapped and write-only addresses read zero.
   always_comb begin
      rdata_d = 32'h0000_0000;
      case (HADDR_I[9:2])
         IDX_BV_CLEAR: rdata_d[7:0] = bv_q;
         IDX_BV_SET: rdata_d[7:0] = bv_q;
         IDX_EV_CTRL: rdata_d[7:0] = ev_ctrl_q;
         IDX_INT_EN: rdata_d[7:0] = int_en_q;
         IDX_INT_FLAGS: rdata_d[7:0] = flags_q;
         IDX_DEBUG: rdata_d[7:0] = debug_q;
         IDX_COUNT: rdata_d[15:0] = COUNT_VALUE_I;
         IDX_PERIOD_BUF: rdata_d[15:0] = period_buf_q;
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   // Read data is registered at the address phase edge.
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         HRDATA_O <= 32'h0000_0000;
      end else if (HREADY_I && HSEL_I && HTRANS_I[1] && !HWRITE_I) begin
         HRDATA_O <= rdata_d;
      end
   end

   // Plain control registers.
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ev_ctrl_q <= RST_BYTE;
         int_en_q <= RST_BYTE;
         debug_q <= RST_BYTE;
         period_buf_q <= RST_PERIOD;
      end else if (wr_en) begin
         if (idx_q == IDX_EV_CTRL) begin
            ev_ctrl_q <= HWDATA_I[7:0];
         end
         if (idx_q == IDX_INT_EN) begin
            int_en_q <= HWDATA_I[7:0] & 8'h71;
         end
         if (idx_q == IDX_DEBUG) begin
            debug_q <= HWDATA_I[7:0] & 8'h01;
         end
         if (idx_q == IDX_PERIOD_BUF) begin
            period_buf_q <= HWDATA_I[15:0];
         end
      end
   end

   assign PERIOD_BUFFER_O = period_buf_q;

   // Compare buffers and compare registers, one set per channel.
   for (genvar n = 0; n < CHANNELS; n++) begin : g_chan
      always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
         if (!RESETN_I) begin
            cmp_buf_q[n] <= RST_CMP;
            cmp_q[n] <= RST_CMP;
         end else begin
            if (wr_en && idx_q == IDX_CMP0_BUF + 8'(n)) begin
               cmp_buf_q[n] <= HWDATA_I[15:0];
            end
            if (UPDATE_I) begin
               cmp_q[n] <= cmp_buf_q[n];
            end
         end
      end
      assign COMPARE_REGISTER_O[16*n +: 16] = cmp_q[n];
      assign cmp_hit[n] = run && (COUNT_VALUE_I == cmp_q[n]);
   end

   // Buffer-valid next value; buffer writes and the set register win over update.
   always_comb begin
      bv_d = bv_q;
      if (UPDATE_I) begin
         bv_d = 8'h00;
      end
      if (wr_en && idx_q == IDX_BV_CLEAR) begin
         bv_d = bv_d & ~(HWDATA_I[7:0] & 8'h0F);
      end
      if (wr_en && idx_q == IDX_BV_SET) begin
         bv_d = bv_d | (HWDATA_I[7:0] & 8'h0F);
      end
      if (wr_en && idx_q == IDX_PERIOD_BUF) begin
         bv_d[BV_PER] = 1'b1;
      end
      for (int n = 0; n < CHANNELS; n++) begin
         if (wr_en && idx_q == IDX_CMP0_BUF + 8'(n)) begin
            bv_d[BV_CMP0 + n] = 1'b1;
         end
      end
   end

   // Buffer-valid register.
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         bv_q <= RST_BYTE;
      end else begin
         bv_q <= bv_d;
      end
   end

   // Timer runs unless the processor is in break debug with debug-run clear.
   assign run = !DEBUG_BREAK_I || debug_q[DBG_RUN];
   assign TIMER_RUN_O = run;

   // Event input sampling for edge detection.
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ev_q <= '0;
      end else begin
         ev_q.a <= EVENT_A_I;
         ev_q.b <= EVENT_B_I;
      end
   end

   assign act_a = ev_ctrl_q[EV_A_ACT_LO +: 3];
   assign act_b = ev_ctrl_q[EV_B_ACT_LO +: 3];
   assign a_on = run && ev_ctrl_q[EV_A_EN];
   assign b_on = run && ev_ctrl_q[EV_B_EN];
   assign a_rise = EVENT_A_I && !ev_q.a;
   assign a_any = EVENT_A_I != ev_q.a;
   assign b_rise = EVENT_B_I && !ev_q.b;
   assign b_any = EVENT_B_I != ev_q.b;

   // Count step source from the input A action.
   always_comb begin
      step = run && PRESCALED_TICK_I;
      if (a_on) begin
         case (act_a)
            A_COUNT_RISING: step = a_rise;
            A_COUNT_EITHER_EDGE: step = a_any;
            A_COUNT_WHILE_HIGH: step = PRESCALED_TICK_I && EVENT_A_I;
            A_DIRECTION_BY_EVENT: step = PRESCALED_TICK_I;
            default: step = 1'b0;
         endcase
      end
   end

   // Direction latched on each count step when an event steers it.
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         dir_q <= 1'b0;
      end else if (step) begin
         if (b_on && act_b == B_DIRECTION_BY_EVENT) begin
            dir_q <= EVENT_B_I;
         end else if (a_on && act_a == A_DIRECTION_BY_EVENT) begin
            dir_q <= EVENT_A_I;
         end
      end
   end

   // Restart command from the input B action.
   always_comb begin
      cmd.count_step = step;
      cmd.count_down = dir_q;
      cmd.restart = 1'b0;
      if (b_on) begin
         case (act_b)
            B_RESTART_RISING: cmd.restart = b_rise;
            B_RESTART_EITHER_EDGE: cmd.restart = b_any;
            B_RESTART_WHILE_HIGH: cmd.restart = EVENT_B_I;
            default: cmd.restart = 1'b0;
         endcase
      end
   end

   assign COUNT_STEP_O = cmd.count_step;
   assign COUNT_DOWN_O = cmd.count_down;
   assign RESTART_O = cmd.restart;

   // Wrap condition chosen by the waveform mode.
   always_comb begin
      case (WAVEFORM_MODE_I)
         3'h0, 3'h1, 3'h5: wrap_hit = AT_TOP_I;
         3'h6: wrap_hit = AT_TOP_I || AT_BOTTOM_I;
         3'h3, 3'h7: wrap_hit = AT_BOTTOM_I;
         default: wrap_hit = 1'b0;
      endcase
   end

   // Sticky flag next value; a hardware set wins over a one-write clear.
   always_comb begin
      flags_d = flags_q;
      if (wr_en && idx_q == IDX_INT_FLAGS) begin
         flags_d = flags_d & ~(HWDATA_I[7:0] & 8'h71);
      end
      if (run && wrap_hit) begin
         flags_d[INT_WRAP] = 1'b1;
      end
      flags_d[INT_CMP0 +: 3] = flags_d[INT_CMP0 +: 3] | cmp_hit;
   end

   // Interrupt flag register.
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         flags_q <= RST_BYTE;
      end else begin
         flags_q <= flags_d;
      end
   end

   // Interrupt requests.
   assign WRAP_IRQ_O = flags_q[INT_WRAP] && int_en_q[INT_WRAP];
   assign COMPARE_IRQ_O = flags_q[INT_CMP0 +: 3] & int_en_q[INT_CMP0 +: 3];

   // Checks.
   a_bv_update: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      UPDATE_I && !wr_en |=> bv_q[3:0] == 4'h0)
      else $error("buffer-valid bits not cleared by update");
   a_bv_period: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      wr_en && idx_q == IDX_PERIOD_BUF |=> bv_q[BV_PER])
      else $error("period buffer-valid not set");
   a_bv_cmp0: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      wr_en && idx_q == IDX_CMP0_BUF |=> bv_q[BV_CMP0])
      else $error("compare buffer-valid not set");
   a_bv_setreg: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      wr_en && idx_q == IDX_BV_SET |=> (bv_q[3:0] & $past(HWDATA_I[3:0])) == $past(HWDATA_I[3:0]))
      else $error("set register failed");
   a_cmp_load: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      UPDATE_I |=> cmp_q[0] == $past(cmp_buf_q[0]))
      else $error("compare not loaded on update");
   a_flag_sticky: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      flags_q[INT_CMP0] && !(wr_en && idx_q == IDX_INT_FLAGS) |=> flags_q[INT_CMP0])
      else $error("compare flag lost");
   a_wrap_sticky: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      flags_q[INT_WRAP] && !(wr_en && idx_q == IDX_INT_FLAGS) |=> flags_q[INT_WRAP])
      else $error("wrap flag lost");
   a_cmp_match: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      run && COUNT_VALUE_I == cmp_q[1] |=> flags_q[INT_CMP0 + 1])
      else $error("compare flag not set on match");
   a_debug_halt: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      DEBUG_BREAK_I && !debug_q[DBG_RUN] |-> !COUNT_STEP_O && !RESTART_O)
      else $error("timer active in break debug");
   a_b_off: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      !ev_ctrl_q[EV_B_EN] |-> !RESTART_O)
      else $error("input B acted while disabled");
   a_irq_level: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      run && wrap_hit && int_en_q[INT_WRAP] && !(wr_en && idx_q == IDX_INT_EN) |=> WRAP_IRQ_O)
      else $error("wrap request mismatch");
   a_wrap_bottom: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      run && WAVEFORM_MODE_I == 3'h3 && AT_BOTTOM_I |=> flags_q[INT_WRAP])
      else $error("wrap flag not set at bottom");
   a_restart_rise: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      b_on && act_b == B_RESTART_RISING && $rose(EVENT_B_I) |-> RESTART_O)
      else $error("no restart on input B rise");
   a_count_rise: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      a_on && act_a == A_COUNT_RISING && $rose(EVENT_A_I) |-> COUNT_STEP_O)
      else $error("no step on input A rise");
   a_a_off: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      run && !ev_ctrl_q[EV_A_EN] |-> COUNT_STEP_O == PRESCALED_TICK_I)
      else $error("input A acted while disabled");
   a_dir_latch: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      COUNT_STEP_O && a_on && act_a == A_DIRECTION_BY_EVENT && act_b != B_DIRECTION_BY_EVENT
      |=> COUNT_DOWN_O == $past(EVENT_A_I))
      else $error("input A direction not latched");
   a_bv_clear: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      wr_en && idx_q == IDX_BV_CLEAR |=> (bv_q[3:0] & $past(HWDATA_I[3:0])) == 4'h0)
      else $error("clear register failed");
   c_restart: cover property (@(posedge CLK_SYS_I) RESTART_O);
   c_irq: cover property (@(posedge CLK_SYS_I) COMPARE_IRQ_O != 3'b000);
   c_down: cover property (@(posedge CLK_SYS_I) COUNT_STEP_O && COUNT_DOWN_O);
   c_bottom: cover property (@(posedge CLK_SYS_I) WAVEFORM_MODE_I == 3'h3 && AT_BOTTOM_I);

endmodule : tec_timer_ctrl

//--- tec_core_model.sv
// Behavioural counter core that faces the timer control block.
// Assumes the block's step, direction and restart hooks share one clock.
`timescale 1ns/1ps
module tec_core_model
   import tec_pkg::*;
#(
   parameter logic [15:0] TOP = 16'h000F
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic resetn_i,
   // Hooks from the control block.
   input wire logic step_i,
   input wire logic down_i,
   input wire logic restart_i,
   // Counter state back to the control block.
   output logic [15:0] count_o,
   output logic at_top_o,
   output logic at_bottom_o,
   output logic update_o
);
   // Top and bottom pulse on the step that leaves the end value.
   assign at_top_o = step_i & ~down_i & (count_o == TOP);
   assign at_bottom_o = step_i & down_i & (count_o == 16'h0000);
   // Normal mode updates the buffered registers at top.
   assign update_o = at_top_o;
   // Restart wins over a step; the count wraps inside zero to top.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count_o <= 16'h0000;
      end else if (restart_i) begin
         count_o <= 16'h0000;
      end else if (step_i) begin
         if (down_i) begin
            count_o <= at_bottom_o ? TOP : count_o - 16'h0001;
         end else begin
            count_o <= at_top_o ? 16'h0000 : count_o + 16'h0001;
         end
      end
   end
endmodule : tec_core_model

//--- tec_timer_ctrl_tb_top.sv
// Self-checking bench for the timer control block.
// Assumes a zero-wait AHB-Lite slave and the core model beside it.
`timescale 1ns/1ps
module tec_timer_ctrl_tb_top;
   import tec_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, hwrite = 1'b0, ev_a = 1'b0, ev_b = 1'b0;
   logic dbg_brk = 1'b1, tick = 1'b0, hreadyout, hresp;
   logic step, down, restart, run, upd, top, bot, wrap_irq;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv, e, s;
   logic [1:0] htrans = 2'h0;
   logic [15:0] cnt, period_buffer;
   logic [47:0] cmp_regs;
   logic [2:0] cmp_irq, wmode = 3'h0;
   int fails = 0, tests_run = 0, cyc = 0;
   string nm_q[$], n;
   logic [31:0] exp_q[$], seen_q[$];

   tec_timer_ctrl i_dut (.CLK_SYS_I(clk), .RESETN_I(rstn), .HSEL_I(1'b1), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
      .HREADY_I(hreadyout), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
      .EVENT_A_I(ev_a), .EVENT_B_I(ev_b), .DEBUG_BREAK_I(dbg_brk), .PRESCALED_TICK_I(tick),
      .UPDATE_I(upd), .AT_TOP_I(top), .AT_BOTTOM_I(bot), .WAVEFORM_MODE_I(wmode),
      .COUNT_VALUE_I(cnt), .COUNT_STEP_O(step), .COUNT_DOWN_O(down), .RESTART_O(restart),
      .TIMER_RUN_O(run), .COMPARE_REGISTER_O(cmp_regs), .PERIOD_BUFFER_O(period_buffer),
      .WRAP_IRQ_O(wrap_irq), .COMPARE_IRQ_O(cmp_irq));
   tec_core_model i_core (.clk_i(clk), .resetn_i(rstn), .step_i(step), .down_i(down),
      .restart_i(restart), .count_o(cnt), .at_top_o(top), .at_bottom_o(bot), .update_o(upd));

   // Free-running 20 MHz clock.
   initial begin
      forever #25 clk = ~clk;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up;
      wait (seen_q.size() == 0);
      $display("Compares %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up

   // Cuts a hang short well past the expected run length.
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         fails++;
         wrap_up();
      end
   end

   // Takes the oldest note whenever a result arrives and compares the two.
   initial begin
      forever begin
         wait (seen_q.size() > 0);
         n = nm_q.pop_front();
         e = exp_q.pop_front();
         s = seen_q.pop_front();
         tests_run++;
         if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
         end
      end
   end

   // Notes an expected value beside the value seen.
   task automatic chk(input string nm, input logic [31:0] ev, input logic [31:0] sv);
      nm_q.push_back(nm);
      exp_q.push_back(ev);
      seen_q.push_back(sv);
   endtask : chk

   // One single word transfer; holds each phase until ready is sampled high.
   task automatic bus(input logic [7:0] idx, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd_o);
      htrans <= 2'h2;
      haddr <= {22'h0, idx, 2'b00};
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd_o = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [15:0] d);
      logic [31:0] r;
      bus(idx, 1'b1, {16'h0, d}, r);
   endtask : wr

   task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] x);
      logic [31:0] r;
      bus(idx, 1'b0, 32'h0, r);
      chk(nm, {24'h0, x}, r);
   endtask : rd

   // Sets an action, shows one event cycle and checks the count step and restart hooks in it.
   task automatic ev(input logic [7:0] c, input logic [1:0] p, input logic [1:0] q,
                     input logic t, input logic es, input logic er);
      wr(IDX_EV_CTRL, {8'h0, c});
      {ev_a, ev_b} <= p;
      tick <= 1'b0;
      @(posedge clk);
      {ev_a, ev_b} <= q;
      tick <= t;
      @(negedge clk);
      chk("count step", {31'h0, es}, {31'h0, step});
      chk("restart", {31'h0, er}, {31'h0, restart});
      @(posedge clk);
   endtask : ev

   // Checks the latched direction one cycle after a step.
   task automatic dn(input logic x);
      @(negedge clk);
      chk("count down", {31'h0, x}, {31'h0, down});
      @(posedge clk);
   endtask : dn

   // Main sequence: reset, registers, event actions, buffers and flags.
   initial begin
      void'($urandom(32'h1B839D07));
      rv = $urandom;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rd("buffer valid", IDX_BV_SET, 8'h00);
      rd("irq enable", IDX_INT_EN, 8'h00);
      rd("irq flags", IDX_INT_FLAGS, 8'h00);
      rd("debug", IDX_DEBUG, 8'h00);
      rd("unmapped", 8'h10, 8'h00);
      rd("event control", IDX_EV_CTRL, 8'h00);
      chk("period buffer", 32'h0000FFFF, {16'h0, period_buffer});
      chk("run", 32'h0, {31'h0, run});
      chk("response", 32'h0, {31'h0, hresp});
      wr(IDX_EV_CTRL, {8'h0, rv[7:0]});
      rd("event control", IDX_EV_CTRL, rv[7:0]);
      wr(IDX_DEBUG, 16'h0001);
      rd("debug", IDX_DEBUG, 8'h01);
      chk("run", 32'h1, {31'h0, run});
      ev(8'h01, 2'b00, 2'b10, 1'b0, 1'b1, 1'b0);
      ev(8'h03, 2'b10, 2'b00, 1'b0, 1'b1, 1'b0);
      ev(8'h05, 2'b10, 2'b10, 1'b1, 1'b1, 1'b0);
      ev(8'h05, 2'b00, 2'b00, 1'b1, 1'b0, 1'b0);
      ev(8'h02, 2'b00, 2'b10, 1'b0, 1'b0, 1'b0);
      ev(8'h07, 2'b10, 2'b10, 1'b1, 1'b1, 1'b0);
      dn(1'b1);
      ev(8'h90, 2'b00, 2'b01, 1'b0, 1'b0, 1'b1);
      ev(8'hB0, 2'b01, 2'b00, 1'b0, 1'b0, 1'b1);
      ev(8'hD0, 2'b01, 2'b01, 1'b0, 1'b0, 1'b1);
      ev(8'hC0, 2'b01, 2'b01, 1'b0, 1'b0, 1'b0);
      ev(8'hF0, 2'b00, 2'b01, 1'b0, 1'b0, 1'b0);
      ev(8'h10, 2'b00, 2'b01, 1'b0, 1'b0, 1'b0);
      ev(8'h77, 2'b01, 2'b01, 1'b1, 1'b1, 1'b0);
      dn(1'b1);
      ev(8'h77, 2'b00, 2'b00, 1'b1, 1'b1, 1'b0);
      dn(1'b0);
      wr(IDX_EV_CTRL, 16'h0000);
      wr(IDX_DEBUG, 16'h0000);
      @(negedge clk);
      chk("halted step", 32'h0, {31'h0, step});
      @(posedge clk);
      wr(IDX_INT_FLAGS, 16'h00FF);
      rd("irq flags", IDX_INT_FLAGS, 8'h00);
      wr(IDX_CMP0_BUF, 16'h0003);
      wr(IDX_CMP0_BUF + 8'h01, 16'h0007);
      wr(IDX_CMP0_BUF + 8'h02, 16'h000B);
      wr(IDX_PERIOD_BUF, 16'h000F);
      rd("buffer valid", IDX_BV_CLEAR, 8'h0F);
      chk("period buffer", 32'h0000000F, {16'h0, period_buffer});
      wr(IDX_BV_CLEAR, 16'h0005);
      rd("buffer valid", IDX_BV_SET, 8'h0A);
      wr(IDX_BV_SET, 16'h0001);
      rd("buffer valid", IDX_BV_SET, 8'h0B);
      wr(IDX_INT_EN, 16'h0011);
      wr(IDX_DEBUG, 16'h0001);
      repeat (40) @(posedge clk);
      wr(IDX_DEBUG, 16'h0000);
      rd("buffer valid", IDX_BV_SET, 8'h00);
      chk("compare 0", 32'h3, {16'h0, cmp_regs[15:0]});
      chk("compare 1", 32'h7, {16'h0, cmp_regs[31:16]});
      chk("compare 2", 32'hB, {16'h0, cmp_regs[47:32]});
      rd("count", IDX_COUNT, cnt[7:0]);
      rd("irq flags", IDX_INT_FLAGS, 8'h71);
      chk("wrap irq", 32'h1, {31'h0, wrap_irq});
      chk("compare irq", 32'h1, {29'h0, cmp_irq});
      wr(IDX_INT_FLAGS, 16'h0000);
      rd("irq flags", IDX_INT_FLAGS, 8'h71);
      wr(IDX_INT_FLAGS, 16'h0010);
      rd("irq flags", IDX_INT_FLAGS, 8'h61);
      chk("compare irq", 32'h0, {29'h0, cmp_irq});
      wr(IDX_INT_FLAGS, 16'h0061);
      rd("irq flags", IDX_INT_FLAGS, 8'h00);
      chk("wrap irq", 32'h0, {31'h0, wrap_irq});
      // Single-slope mode: counting up never sets the wrap flag, counting down does.
      wmode <= 3'h3;
      wr(IDX_DEBUG, 16'h0001);
      repeat (20) @(posedge clk);
      rd("irq flags", IDX_INT_FLAGS, 8'h70);
      wr(IDX_INT_FLAGS, 16'h0070);
      ev_a <= 1'b1;
      wr(IDX_EV_CTRL, 16'h0007);
      repeat (20) @(posedge clk);
      rd("irq flags", IDX_INT_FLAGS, 8'h71);
      wrap_up();
   end
endmodule : tec_timer_ctrl_tb_top
